// >>> bench/clock_out_and_portc_mux_checker.sv
// assertions on the clock-out and port c routing block
`timescale 1ns/1ns
module clock_out_and_portc_mux_checker (
    // clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input clock_out_mux_pkg::apb_req_s apb_req,
    // clock pin, its sources and the pin b7 oscillator clock
    input wire logic core_system_clock,
    input wire logic raw_oscillator_clock,
    input wire logic pll_output_clock,
    input clock_out_mux_pkg::pad_drive_s clock_output_pin,
    // port b
    input wire logic [3:0] portb_peripheral_enable,
    input wire logic [3:0] portb_gpio_out,
    input wire logic [3:0] portb_pin_out,
    input wire logic [3:0] portb_pin_oe_n,
    // port c
    input wire logic [3:0] portc_peripheral_enable,
    input wire logic [3:0] portc_direction,
    input wire logic [3:0] timer_output_enable,
    input wire logic [3:0] spi_two_drive,
    input wire logic [3:0] portc_pin_oe_n,
    // registers
    input wire logic [15:0] clock_out_select,
    input wire logic [15:0] portc_function_select
);
    import clock_out_mux_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a completed write to the clock-out select
    wire wr_cos = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == 12'h028;
    property p_rsv;
        clock_out_select[15:10] == 6'h00 && portc_function_select[15:4] == 12'h000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    property p_wr;
        wr_cos |=> clock_out_select == {6'h00, $past(apb_req.pwdata[9:0])};
    endproperty
    a_wr: assert property (p_wr) else $error("write not taken");
    property p_hold;
        !wr_cos |=> $stable(clock_out_select);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed unasked");
    property p_b7;
        portb_peripheral_enable[3] && clock_out_select[9]
            |-> portb_pin_out[3] == raw_oscillator_clock && !portb_pin_oe_n[3];
    endproperty
    a_b7: assert property (p_b7) else $error("pin b7 not on oscillator");
    property p_bgp;
        !portb_peripheral_enable[1] |-> portb_pin_out[1] == portb_gpio_out[1];
    endproperty
    a_bgp: assert property (p_bgp) else $error("pin b5 not gpio");
    property p_dis;
        clock_output_pin.oe_n == clock_out_select[5];
    endproperty
    a_dis: assert property (p_dis) else $error("clock pin enable wrong");
    property p_sys;
        clock_out_select[5:0] == 6'h00 |-> clock_output_pin.out == core_system_clock;
    endproperty
    a_sys: assert property (p_sys) else $error("default source wrong");
    property p_pll;
        clock_out_select[4:0] == 5'h08 |-> clock_output_pin.out == pll_output_clock;
    endproperty
    a_pll: assert property (p_pll) else $error("pll source wrong");
    property p_gpio;
        !portc_peripheral_enable[0] |-> portc_pin_oe_n[0] == !portc_direction[0];
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio direction wrong");
    property p_tmr;
        portc_peripheral_enable[2] && !portc_function_select[2]
            |-> portc_pin_oe_n[2] == !timer_output_enable[2];
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer direction wrong");
    property p_spi;
        portc_peripheral_enable[3] && portc_function_select[3]
            |-> portc_pin_oe_n[3] == !spi_two_drive[3];
    endproperty
    a_spi: assert property (p_spi) else $error("spi direction wrong");
    // main scenarios reached
    c_wr: cover property (wr_cos);
    c_spi: cover property (portc_peripheral_enable[3] && portc_function_select[3]);
    c_pll: cover property (clock_out_select[5:0] == 6'h08);
endmodule

bind clock_out_and_portc_mux clock_out_and_portc_mux_checker u_chk (.pclk, .presetn,
    .apb_req, .core_system_clock, .raw_oscillator_clock, .pll_output_clock,
    .clock_output_pin, .portb_peripheral_enable, .portb_gpio_out, .portb_pin_out,
    .portb_pin_oe_n, .portc_peripheral_enable, .portc_direction, .timer_output_enable,
    .spi_two_drive, .portc_pin_oe_n, .clock_out_select, .portc_function_select);

// >>> bench/clock_out_and_portc_mux_tb.sv
// self-checking bench for the clock-out and port c routing block
`timescale 1ns/1ns
module clock_out_and_portc_mux_tb;
    import clock_out_mux_pkg::*;
    // bench signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_s req = '0;
    apb_rsp_s rsp;
    pad_drive_s ck;
    logic [22:0] src;
    logic [3:0] portb_peripheral_enable = 4'h0, portb_gpio_out = 4'h0, portb_gpio_drive = 4'h0;
    logic [3:0] external_address_hi = 4'h0, portc_peripheral_enable = 4'h0, far = 4'h0;
    logic [3:0] portc_direction = 4'h0, portc_gpio_out = 4'h0, timer_output_enable = 4'h0;
    logic [3:0] timer_b_out = 4'h0, spi_two_out = 4'h0, spi_two_drive = 4'h0, alt;
    logic [3:0] portb_pin_out, portb_pin_oe_n, portc_gpio_in, timer_b_in, decoder_in;
    logic [3:0] spi_two_in, portc_pin_in, portc_pin_out, portc_pin_oe_n, oe;
    logic err;
    logic [15:0] cos, pfs, rd, seen;
    logic [7:0] rnd = 8'h1a;
    logic [18:0] nq;
    logic [18:0] expq[$];
    string nm[6] = '{"prdata", "clock pin", "port b", "port c", "port c inputs", "slave error"};
    int n_fail = 0;
    int n_compared = 0;
    event chk;
    // clock
    initial begin
        forever #50 pclk = ~pclk;
    end
    pad_partner u_pad (.pclk, .pin_out(portc_pin_out), .pin_oe_n(portc_pin_oe_n),
        .far_level(far), .pin_in(portc_pin_in), .src);
    clock_out_and_portc_mux u_dut (.pclk, .presetn, .apb_req(req), .apb_rsp(rsp),
        .core_system_clock(src[0]), .secondary_system_clock(src[1]),
        .raw_oscillator_clock(src[2]), .prescaler_reference_clock(src[3]),
        .oscillator_output_clock(src[4]), .pll_output_clock(src[5]),
        .converter_a_clock(src[6]), .converter_b_clock(src[7]),
        .factory_test_clocks(src[22:8]), .clock_output_pin(ck),
        .portb_peripheral_enable, .portb_gpio_out, .portb_gpio_drive, .external_address_hi,
        .portb_pin_out, .portb_pin_oe_n, .portc_peripheral_enable, .portc_direction,
        .portc_gpio_out, .portc_gpio_in, .timer_output_enable, .timer_b_out, .timer_b_in,
        .decoder_in, .spi_two_out, .spi_two_drive, .spi_two_in, .portc_pin_in,
        .portc_pin_out, .portc_pin_oe_n, .clock_out_select(cos), .portc_function_select(pfs));
    // next pseudo-random byte
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // expected clock pin level for a selector code
    function automatic logic exp_clk(input logic [4:0] c);
        case (c)
            5'h00: return src[0];
            5'h07: return src[4];
            5'h08: return src[5];
            5'h10: return src[6];
            5'h11: return src[7];
            default: return (c < 5'h10) ? src[5'd7 + c] : 1'b0;
        endcase
    endfunction
    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    // queue an expectation and tell the watcher a result is showing
    task automatic note(input logic [2:0] c, input logic [15:0] e);
        expq.push_back({c, e});
        ->chk;
        #1;
    endtask
    // watcher: pairs the shown result with the oldest note
    always @(chk) begin
        nq = expq.pop_front();
        case (nq[18:16])
            3'd0: seen = rd;
            3'd1: seen = {14'h0, ck.oe_n, ck.out & ~ck.oe_n};
            3'd2: seen = {8'h0, portb_pin_oe_n, portb_pin_out & ~portb_pin_oe_n};
            3'd3: seen = {8'h0, portc_pin_oe_n, portc_pin_out & ~portc_pin_oe_n};
            3'd4: seen = {portc_gpio_in, timer_b_in, decoder_in, spi_two_in};
            default: seen = {15'h0, err};
        endcase
        check(nm[nq[18:16]], seen, nq[15:0]);
    end
    // one apb transfer: setup, access until pready, then release
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int n;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, {16'h0, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            end_sim();
        end
        rd = rsp.prdata[15:0];
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // port c expectation per pin from its own controls
    task automatic exp_c(input logic [3:0] s);
        logic [3:0] g, t, p, en, o, pin;
        g = ~portc_peripheral_enable;
        t = portc_peripheral_enable & ~s;
        p = portc_peripheral_enable & s;
        en = g & portc_direction | t & timer_output_enable | p & spi_two_drive;
        o = g & portc_gpio_out | t & timer_b_out | p & spi_two_out;
        pin = en & o | ~en & far;
        note(3'd3, {8'h0, ~en, o & en});
        note(3'd4, {g & pin, t & pin, t & pin, p & pin});
    endtask
    // main sequence
    initial begin
        for (int k = 0; k < 2; k++) begin
            presetn <= 1'b0;
            repeat (12) @(posedge pclk);
            presetn <= 1'b1;
            apb(1'b0, 12'h028, 16'h0); note(3'd0, 16'h0020);
            apb(1'b0, 12'h02c, 16'h0); note(3'd0, 16'h0000);
            @(negedge pclk); note(3'd1, 16'h0002);
            apb(1'b1, 12'h028, 16'hffff);
            apb(1'b1, 12'h02c, 16'hffff);
            apb(1'b1, 12'h030, 16'hffff);
            note(3'd5, 16'h0000);
            apb(1'b0, 12'h028, 16'h0); note(3'd0, 16'h03ff);
            apb(1'b0, 12'h02c, 16'h0); note(3'd0, 16'h000f);
            apb(1'b0, 12'h030, 16'h0); note(3'd0, 16'h0000);
            note(3'd5, 16'h0000);
        end
        // every selector code with the pin enabled
        for (int c = 0; c < 32; c++) begin
            apb(1'b1, 12'h028, c[15:0]);
            repeat (3) begin
                @(negedge pclk); note(3'd1, {15'h0, exp_clk(c[4:0])});
            end
        end
        // port b: random enables, alternate picks and gpio
        repeat (12) begin
            rnd = lfsr(rnd);
            alt = rnd[7:4];
            apb(1'b1, 12'h028, {6'h00, alt, 6'h20});
            rnd = lfsr(rnd);
            portb_peripheral_enable <= rnd[3:0];
            portb_gpio_out <= rnd[7:4];
            rnd = lfsr(rnd);
            portb_gpio_drive <= rnd[3:0];
            external_address_hi <= rnd[7:4];
            @(negedge pclk);
            alt = alt & {src[2], src[1], src[0], src[3]} | ~alt & external_address_hi;
            alt = portb_peripheral_enable & alt | ~portb_peripheral_enable & portb_gpio_out;
            oe = ~(portb_peripheral_enable | portb_gpio_drive);
            note(3'd2, {8'h0, oe, alt & ~oe});
        end
        // port c: random controls and selects on all four pins
        repeat (16) begin
            rnd = lfsr(rnd);
            alt = rnd[3:0];
            apb(1'b1, 12'h02c, {12'h0, alt});
            portc_peripheral_enable <= rnd[7:4];
            rnd = lfsr(rnd);
            {portc_direction, portc_gpio_out} <= rnd;
            rnd = lfsr(rnd);
            {timer_output_enable, timer_b_out} <= rnd;
            rnd = lfsr(rnd);
            {spi_two_out, spi_two_drive} <= rnd;
            rnd = lfsr(rnd);
            far <= rnd[3:0];
            @(negedge pclk);
            exp_c(alt);
        end
        end_sim();
    end
endmodule

// >>> bench/pad_partner.sv
// pads and clock sources around the routing block
`timescale 1ns/1ns
module pad_partner (
    // clock
    input wire logic pclk,
    // port c pad drive and far-side level
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] far_level,
    // pad level back to the block and clock sources
    output logic [3:0] pin_in,
    output logic [22:0] src
);
    logic [22:0] sr = 23'h5a3c1;
    // sources change every rising edge so a wrong route shows up
    always @(posedge pclk) begin
        sr <= {sr[21:0], sr[22] ^ sr[17]};
    end
    // wire level: the block when its enable is low, else the far side
    assign src = sr;
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & far_level);
endmodule

// >>> include/clock_out_mux_pkg.sv
// types shared by the clock-out and port c routing block
package clock_out_mux_pkg;
    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    // one pad's controls: output, output enable (low drives)
    typedef struct packed {
        logic out;
        logic oe_n;
    } pad_drive_s;

    // function that owns a port c pin
    typedef enum logic [1:0] {
        owner_gpio,
        owner_timer,
        owner_spi
    } pin_owner_e;

    // source of the clock output pin
    typedef logic [4:0] clock_source_t;
endpackage

// >>> include/clock_out_mux_regs.svh
// register offsets, field positions and reset values of the clock-out and port c selects
`ifndef CLOCK_OUT_MUX_REGS_SVH
`define CLOCK_OUT_MUX_REGS_SVH

// register indices and byte addresses (index times four)
`define CLOCK_OUT_SELECT_IDX 4'ha
`define PORTC_FUNCTION_SELECT_IDX 4'hb
`define CLOCK_OUT_SELECT_ADDR 12'h028
`define PORTC_FUNCTION_SELECT_ADDR 12'h02c

// register width and implemented bits
`define REG_WIDTH 16
`define CLOCK_OUT_SELECT_MASK 16'h03ff
`define PORTC_FUNCTION_SELECT_MASK 16'h000f

// field positions in clock_out_select
`define ALT_SELECT_HI 9
`define ALT_SELECT_LO 6
`define CLOCK_OUT_DISABLE_BIT 5
`define CLOCK_OUT_SOURCE_HI 4
`define CLOCK_OUT_SOURCE_LO 0

// reset values
`define CLOCK_OUT_SELECT_RESET 16'h0020
`define PORTC_FUNCTION_SELECT_RESET 16'h0000

// clock source selector codes
`define SRC_SYSTEM 5'h00
`define SRC_TEST_FIRST 5'h01
`define SRC_OSCILLATOR 5'h07
`define SRC_PLL 5'h08
`define SRC_CONVERTER_A 5'h10
`define SRC_CONVERTER_B 5'h11

`endif

// >>> src/clock_out_and_portc_mux.sv
// clock output select, port b upper pin routing and port c function routing
// Contract
// - unimplemented upper bits read zero, ignore writes
// - select bit 9: pin b7 address or oscillator
// - select bit 8: pin b6 address or clock2
// - select bit 7: pin b5 address or sysclock
// - select bit 6: pin b4 address or reference
// - port b peripheral enable has priority
// - disable bit resets one, tri-states clock pin
// - five-bit source selector, resets to system clock
// - codes map oscillator, pll, converter a, b
// - factory test codes route internal test clocks
// - port b alternate bits reset to address
// - port c bit 3: home/timer or slave select
// - port c bit 2: index/timer or master in
// - gpio mode uses port direction bit
// - timer output enable sets timer pin direction
// - spi controls set direction in spi mode
// - each port c pin routed independently
// - decoder path never drives port c pins
// - port c select resets to all zeros
// - port c bit 1: phase b/timer or master out
// - port c bit 0: phase a/timer or serial clock
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`include "clock_out_mux_regs.svh"
module clock_out_and_portc_mux (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input clock_out_mux_pkg::apb_req_s apb_req,
    output clock_out_mux_pkg::apb_rsp_s apb_rsp,
    // clock sources for the clock output pin and the port b extra clocks
    input wire logic core_system_clock,
    input wire logic secondary_system_clock,
    input wire logic raw_oscillator_clock,
    input wire logic prescaler_reference_clock,
    input wire logic oscillator_output_clock,
    input wire logic pll_output_clock,
    input wire logic converter_a_clock,
    input wire logic converter_b_clock,
    input wire logic [14:0] factory_test_clocks,
    // clock output pin
    output clock_out_mux_pkg::pad_drive_s clock_output_pin,
    // port b upper pins
    input wire logic [3:0] portb_peripheral_enable,
    input wire logic [3:0] portb_gpio_out,
    input wire logic [3:0] portb_gpio_drive,
    input wire logic [3:0] external_address_hi,
    output logic [3:0] portb_pin_out,
    output logic [3:0] portb_pin_oe_n,
    // port c gpio controls
    input wire logic [3:0] portc_peripheral_enable,
    input wire logic [3:0] portc_direction,
    input wire logic [3:0] portc_gpio_out,
    output logic [3:0] portc_gpio_in,
    // decoder and timer b channels 3..0
    input wire logic [3:0] timer_output_enable,
    input wire logic [3:0] timer_b_out,
    output logic [3:0] timer_b_in,
    output logic [3:0] decoder_in,
    // second spi channel: 3 slave select, 2 master in, 1 master out, 0 serial clock
    input wire logic [3:0] spi_two_out,
    input wire logic [3:0] spi_two_drive,
    output logic [3:0] spi_two_in,
    // port c pads
    input wire logic [3:0] portc_pin_in,
    output logic [3:0] portc_pin_out,
    output logic [3:0] portc_pin_oe_n,
    // register contents seen by other logic
    output logic [15:0] clock_out_select,
    output logic [15:0] portc_function_select
);
    import clock_out_mux_pkg::*;

    logic write_access;
    logic read_setup;
    logic [1:0] reg_sel;
    logic [31:0] next_prdata;
    logic [31:0] prdata_q;
    logic read_hit;
    logic clock_out_disable;
    clock_source_t clock_out_source;
    logic clock_output_signal;
    logic [3:0] alt_clock;
    logic [3:0] alt_select;
    logic test_code;
    logic [3:0] test_index;
    logic [3:0] portb_periph_out;

    // decode of the register byte address
    function automatic logic [1:0] reg_hit(input logic [11:0] addr);
        reg_hit = {addr == `PORTC_FUNCTION_SELECT_ADDR, addr == `CLOCK_OUT_SELECT_ADDR};
    endfunction

    // factory test codes sit below converter a, apart from the two
    // documented sources that share that range
    function automatic logic is_test_code(input clock_source_t code);
        is_test_code = (code >= `SRC_TEST_FIRST) && (code < `SRC_CONVERTER_A)
            && (code != `SRC_OSCILLATOR) && (code != `SRC_PLL);
    endfunction

    // zero-wait-state apb: write in access phase, read data latched at setup
    assign write_access = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign read_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    // no wait states: every access phase lasts exactly one cycle
    assign apb_rsp.pready = 1'b1;
    // no error answer: unmapped reads give zero, unmapped writes are dropped
    assign apb_rsp.pslverr = 1'b0;
    assign apb_rsp.prdata = prdata_q;

    // one address decode shared by the write enables and the read mux
    assign reg_sel = reg_hit(apb_req.paddr);

    // clock-out select register
    // asynchronous reset load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_out_select <= `CLOCK_OUT_SELECT_RESET;
        end else if (write_access && reg_sel[0]) begin
            clock_out_select <= apb_req.pwdata[15:0] & `CLOCK_OUT_SELECT_MASK;
        end
    end

    // port c function select register
    // resets to zeros
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            portc_function_select <= `PORTC_FUNCTION_SELECT_RESET;
        end else if (write_access && reg_sel[1]) begin
            portc_function_select <= apb_req.pwdata[15:0] & `PORTC_FUNCTION_SELECT_MASK;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        read_hit = 1'b0;
        next_prdata = 32'h00000000;
        if (reg_sel[0]) begin
            read_hit = 1'b1;
            next_prdata = {16'h0000, clock_out_select};
        end else if (reg_sel[1]) begin
            read_hit = 1'b1;
            next_prdata = {16'h0000, portc_function_select};
        end
    end

    // read data register, loaded in the setup cycle
    // held through the access phase so the master takes a settled word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (read_setup) begin
            prdata_q <= read_hit ? next_prdata : 32'h00000000;
        end
    end

    // field extraction
    assign clock_out_disable = clock_out_select[`CLOCK_OUT_DISABLE_BIT];
    assign clock_out_source = clock_out_select[`CLOCK_OUT_SOURCE_HI:`CLOCK_OUT_SOURCE_LO];
    assign alt_select = clock_out_select[`ALT_SELECT_HI:`ALT_SELECT_LO];

    // factory test decode: code k+1 takes test clock k
    assign test_code = is_test_code(clock_out_source);
    assign test_index = 4'(clock_out_source - `SRC_TEST_FIRST);

    // clock output source selector
    // plain logic: switch sources only while the pin is disabled,
    // otherwise a runt pulse can reach the pad
    // default system clock
    always_comb begin
        case (clock_out_source)
            `SRC_SYSTEM: clock_output_signal = core_system_clock;
            `SRC_OSCILLATOR: clock_output_signal = oscillator_output_clock;
            `SRC_PLL: clock_output_signal = pll_output_clock;
            `SRC_CONVERTER_A: clock_output_signal = converter_a_clock;
            `SRC_CONVERTER_B: clock_output_signal = converter_b_clock;
            default: begin
                if (test_code) begin
                    clock_output_signal = factory_test_clocks[test_index];
                end else begin
                    clock_output_signal = 1'b0;
                end
            end
        endcase
    end

    // clock output pad
    // tri-state while disabled
    assign clock_output_pin.out = clock_output_signal;
    assign clock_output_pin.oe_n = clock_out_disable;

    // extra clocks for port b pins 7..4
    // pin 7 oscillator
    assign alt_clock[3] = raw_oscillator_clock;
    assign alt_clock[2] = secondary_system_clock;
    assign alt_clock[1] = core_system_clock;
    assign alt_clock[0] = prescaler_reference_clock;

    // port b upper pins, peripheral function takes priority
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : gen_portb
            // address bit or extra clock for the peripheral function
            assign portb_periph_out[b] = alt_select[b] ? alt_clock[b] : external_address_hi[b];
            assign portb_pin_out[b] = portb_peripheral_enable[b]
                ? portb_periph_out[b]
                : portb_gpio_out[b];
            // peripheral function is output only, so the pad is driven there
            assign portb_pin_oe_n[b] = portb_peripheral_enable[b] ? 1'b0 : ~portb_gpio_drive[b];
        end
    endgenerate

    // port c pins, one independent cell each
    // per-pin controls
    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : gen_portc
            pad_drive_s pad;
            logic timer_in_c;
            pad_route_cell u_cell (
                .peripheral_enable(portc_peripheral_enable[c]),
                .direction(portc_direction[c]),
                .function_select(portc_function_select[c]),
                .timer_output_enable(timer_output_enable[c]),
                .gpio_out(portc_gpio_out[c]),
                .timer_out(timer_b_out[c]),
                .spi_out(spi_two_out[c]),
                .spi_drive(spi_two_drive[c]),
                .pad_in(portc_pin_in[c]),
                .pad(pad),
                .owner(),
                .gpio_in(portc_gpio_in[c]),
                .timer_in(timer_in_c),
                .spi_in(spi_two_in[c])
            );
            assign portc_pin_out[c] = pad.out;
            assign portc_pin_oe_n[c] = pad.oe_n;
            assign timer_b_in[c] = timer_in_c;
            assign decoder_in[c] = timer_in_c;
        end
    endgenerate
endmodule

// >>> src/pad_route_cell.sv
// routing of one port c pin between gpio, decoder/timer and the second spi channel
`timescale 1ns/1ns
module pad_route_cell (
    // controls of this pin only
    input wire logic peripheral_enable,
    input wire logic direction,
    input wire logic function_select,
    input wire logic timer_output_enable,
    // sources offered to the pin
    input wire logic gpio_out,
    input wire logic timer_out,
    input wire logic spi_out,
    input wire logic spi_drive,
    input wire logic pad_in,
    // pad drive and inputs handed back
    output clock_out_mux_pkg::pad_drive_s pad,
    output clock_out_mux_pkg::pin_owner_e owner,
    output logic gpio_in,
    output logic timer_in,
    output logic spi_in
);
    import clock_out_mux_pkg::*;

    // owner decode, gpio first then select bit
    always_comb begin
        if (!peripheral_enable) begin
            owner = owner_gpio;
        end else if (function_select) begin
            owner = owner_spi;
        end else begin
            owner = owner_timer;
        end
    end

    // pad drive by owner; decoder never drives, timer only when enabled
    always_comb begin
        pad.out = 1'b0;
        pad.oe_n = 1'b1;
        case (owner)
            owner_gpio: begin
                pad.out = gpio_out;
                pad.oe_n = ~direction;
            end
            owner_timer: begin
                pad.out = timer_out;
                pad.oe_n = ~timer_output_enable;
            end
            owner_spi: begin
                pad.out = spi_out;
                pad.oe_n = ~spi_drive;
            end
            default: begin
                pad.out = 1'b0;
                pad.oe_n = 1'b1;
            end
        endcase
    end

    // input returns, gated to the owner
    assign gpio_in = (owner == owner_gpio) ? pad_in : 1'b0;
    assign timer_in = (owner == owner_timer) ? pad_in : 1'b0;
    assign spi_in = (owner == owner_spi) ? pad_in : 1'b0;
endmodule
